// File: inc/sle_defs.svh
/*
 Offsets, reset values, code boundaries and timing counts of the step sequence logic engine.
 Assumes a 250 MHz pclk and an APB register bus with 12 address bits in use.
*/
`ifndef SLE_DEFS_SVH
`define SLE_DEFS_SVH

`define SLE_NUM_STEPS 14
`define SLE_NUM_OUTS 7
`define SLE_NUM_DIN 8
`define SLE_NUM_AIN 4
`define SLE_SET_PER_STEP 5

`define SLE_MODE_OFF 12'h000
`define SLE_STEP_BASE 12'h100
`define SLE_STEP_LAST 12'h214
`define SLE_ROUTE_BASE 12'h300
`define SLE_ROUTE_LAST 12'h318
`define SLE_FUNC_BASE 12'h320
`define SLE_FUNC_LAST 12'h338
`define SLE_STAT_DIG_OFF 12'h340
`define SLE_STAT_OUT_OFF 12'h344
`define SLE_RSVD_OFF 12'h348
`define SLE_ANA_BASE 12'h380
`define SLE_ANA_LAST 12'h3B4

`define SLE_MODE_RST 1'b0
`define SLE_SET_RST 16'h0000
`define SLE_ROUTE_RST 4'h0
`define SLE_FUNC_RST 8'h00

`define SLE_DIG_LO 16'h0001
`define SLE_DIG_HI 16'h07CF
`define SLE_ANA_LO 16'h07D1
`define SLE_ANA_HI 16'h0F9F
`define SLE_MIX_LO 16'h0FA1
`define SLE_MIX_HI 16'h176F
`define SLE_ANA_OP_BASE 16'h07D0
`define SLE_MIX_OP_BASE 16'h0FA0
`define SLE_SEL_EXT_BASE 16'h0064

`define SLE_PERIOD_MS 5
`define SLE_CLK_KHZ 250000
`define SLE_PERIOD_CYCLES (`SLE_PERIOD_MS * `SLE_CLK_KHZ)

`endif

// File: inc/sle_pkg.sv
/*
 Types and the class decode of the step sequence logic engine.
 Assumes sle_defs.svh is on the include path.
*/
`include "sle_defs.svh"
package sle_pkg;
	typedef enum logic [1:0] {CLS_NONE, CLS_DIG, CLS_ANA, CLS_MIX} step_class_type;
	typedef enum {SEQ_IDLE, SEQ_STEP, SEQ_PUBLISH} seq_state_type;

	function automatic step_class_type class_of(input logic [15:0] code);
		if (code >= `SLE_DIG_LO && code <= `SLE_DIG_HI) begin
			return CLS_DIG;
		end else if (code >= `SLE_ANA_LO && code <= `SLE_ANA_HI) begin
			return CLS_ANA;
		end else if (code >= `SLE_MIX_LO && code <= `SLE_MIX_HI) begin
			return CLS_MIX;
		end
		return CLS_NONE;
	endfunction
endpackage

// File: inc/sle_step_if.sv
/*
 Carrier between the sequencer and the shared step evaluator.
 Assumes the evaluator is purely combinational.
*/
`timescale 1ns/1ps
interface sle_step_if;
	logic [15:0] code;
	logic din_a;
	logic din_b;
	logic [15:0] ain_a;
	logic [15:0] p1;
	logic [15:0] p2;
	logic [15:0] ain_b;
	logic [15:0] st_cnt;
	logic st_pa;
	logic st_px;
	logic st_l;
	logic [15:0] st_hold;
	logic dout;
	logic [15:0] aout;
	logic [15:0] n_cnt;
	logic n_pa;
	logic n_px;
	logic n_l;
	logic [15:0] n_hold;

	modport seq (output code, din_a, din_b, ain_a, ain_b, p1, p2, st_cnt, st_pa, st_px, st_l, st_hold,
		input dout, aout, n_cnt, n_pa, n_px, n_l, n_hold);
	modport unit (input code, din_a, din_b, ain_a, ain_b, p1, p2, st_cnt, st_pa, st_px, st_l, st_hold,
		output dout, aout, n_cnt, n_pa, n_px, n_l, n_hold);
endinterface

// File: verilog/sle_tick_gen.sv
/*
 Divider that gives a one-cycle pulse once every processing period.
 Assumes a single free-running pclk.
*/
`timescale 1ns/1ps
`include "sle_defs.svh"
module sle_tick_gen #(
	parameter int unsigned TICK_CYCLES = `SLE_PERIOD_CYCLES
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Period pulse.
	output logic tick_ff
);
	logic [31:0] cnt_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 32'h0000_0000;
			tick_ff <= 1'b0;
		end else if (cnt_ff >= TICK_CYCLES - 32'h0000_0001) begin
			cnt_ff <= 32'h0000_0000;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 32'h0000_0001;
			tick_ff <= 1'b0;
		end
	end
endmodule

// File: verilog/sle_step_unit.sv
/*
 Combinational evaluator of one step for one processing period.
 Assumes the sequencer feeds the selected inputs and the step's own state and stores the results.
*/
`timescale 1ns/1ps
`include "sle_defs.svh"
module sle_step_unit (
	// Step operands, state and results.
	sle_step_if.unit s
);
	always_comb begin
		sle_pkg::step_class_type cls;
		logic [15:0] grp;
		logic [15:0] tmr;
		logic [15:0] op;
		logic [15:0] inc;
		logic [16:0] sum;
		logic x;
		logic rise;
		cls = sle_pkg::class_of(s.code);
		grp = s.code / 16'h000A;
		tmr = s.code % 16'h000A;
		op = 16'h0000;
		inc = (s.st_cnt == 16'hFFFF) ? s.st_cnt : s.st_cnt + 16'h0001;
		sum = {1'b0, s.ain_a} + {1'b0, s.ain_b};
		x = 1'b0;
		rise = 1'b0;
		s.dout = 1'b0;
		s.aout = 16'h0000;
		s.n_cnt = s.st_cnt;
		s.n_pa = s.din_a;
		s.n_px = s.st_px;
		s.n_l = s.st_l;
		s.n_hold = s.st_hold;
		case (cls)
			sle_pkg::CLS_DIG: begin
				case (grp)
					16'h0001: x = s.din_a;
					16'h0002: x = s.din_a & s.din_b;
					16'h0003: x = s.din_a | s.din_b;
					16'h0004: x = s.din_a ^ s.din_b;
					16'h0005: x = s.din_a | (~s.din_b & s.st_l);
					16'h0006: x = ~s.din_b & (s.din_a | s.st_l);
					16'h0007: x = s.din_a & ~s.st_pa;
					16'h0008: x = ~s.din_a & s.st_pa;
					16'h0009: x = s.din_a ^ s.st_pa;
					16'h000A: x = s.din_b ? s.st_l : s.din_a;
					default: x = 1'b0;
				endcase
				s.n_l = x;
				rise = x & ~s.st_px;
				s.n_px = x;
				if (grp == 16'h000B) begin
					s.n_cnt = s.din_b ? 16'h0000 : ((s.din_a & ~s.st_pa) ? inc : s.st_cnt);
					s.dout = (s.n_cnt >= s.p1) && !s.din_b;
				end else if (grp != 16'h0000) begin
					case (tmr)
						16'h0000: s.dout = x;
						16'h0001: begin
							s.n_cnt = x ? inc : 16'h0000;
							s.dout = x && (s.n_cnt >= s.p1);
						end
						16'h0002: begin
							s.n_cnt = x ? 16'h0000 : inc;
							s.dout = x || (s.st_hold[0] && (s.n_cnt < s.p1));
							s.n_hold = {15'h0000, s.dout};
						end
						16'h0003, 16'h0004: begin
							if (rise && (tmr == 16'h0004 || s.st_cnt == 16'h0000)) begin
								s.n_cnt = s.p1;
							end else if (s.st_cnt != 16'h0000) begin
								s.n_cnt = s.st_cnt - 16'h0001;
							end
							s.dout = rise ? (s.p1 != 16'h0000) : (s.st_cnt > 16'h0001);
						end
						16'h0005: begin
							if (!x) begin
								s.n_cnt = 16'h0000;
								s.n_hold = 16'h0000;
							end else if (inc >= s.p1) begin
								s.n_cnt = 16'h0000;
								s.n_hold = {15'h0000, ~s.st_hold[0]};
							end else begin
								s.n_cnt = inc;
							end
							s.dout = s.n_hold[0];
						end
						default: s.dout = 1'b0;
					endcase
				end
			end
			sle_pkg::CLS_ANA: begin
				op = s.code - `SLE_ANA_OP_BASE;
				case (op)
					16'h0001: s.aout = sum[16] ? 16'hFFFF : sum[15:0];
					16'h0002: s.aout = (s.ain_a > s.ain_b) ? s.ain_a - s.ain_b : 16'h0000;
					16'h0003: s.aout = (s.ain_a > s.ain_b) ? s.ain_a : s.ain_b;
					16'h0004: s.aout = (s.ain_a < s.ain_b) ? s.ain_a : s.ain_b;
					16'h0005: s.aout = sum[16:1];
					16'h0006: s.dout = s.ain_a >= s.ain_b;
					16'h0007: s.dout = s.ain_a < s.ain_b;
					16'h0008: s.dout = s.ain_a >= s.p1;
					16'h0009: s.aout = (s.ain_a < s.p1) ? s.p1 : ((s.ain_a > s.p2) ? s.p2 : s.ain_a);
					16'h000A: s.dout = (s.ain_a >= s.p1) && (s.ain_a <= s.p2);
					default: s.aout = 16'h0000;
				endcase
			end
			sle_pkg::CLS_MIX: begin
				op = s.code - `SLE_MIX_OP_BASE;
				case (op)
					16'h0001: s.aout = s.din_b ? s.ain_a : s.p1;
					16'h0002: s.aout = s.din_b ? s.p1 : s.p2;
					16'h0003: s.aout = s.din_b ? s.st_hold : s.ain_a;
					16'h0004: s.aout = s.din_b ? s.ain_a : 16'h0000;
					default: s.aout = 16'h0000;
				endcase
				s.n_hold = s.aout;
			end
			default: begin
				s.dout = 1'b0;
				s.n_cnt = 16'h0000;
			end
		endcase
	end
endmodule

// File: verilog/sle_engine.sv
/*
 Step sequence logic engine: APB register file, period sequencer over fourteen steps and seven general outputs.
 Assumes an APB master on pclk, digital and analog inputs synchronous to pclk.
*/
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "sle_defs.svh"
module sle_engine #(
	parameter int unsigned TICK_CYCLES = `SLE_PERIOD_CYCLES
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_ff,
	output logic pready_ff,
	output logic pslverr_ff,
	// Drive signals in.
	input wire logic [7:0] dig_in,
	input wire logic [3:0][15:0] ana_in,
	// Engine results out.
	output logic [6:0] gen_out_ff,
	output logic [13:0] step_dig_ff,
	output logic period_done_ff
);
	logic mode_ff;
	logic [15:0] cfg_ff [70];
	logic [3:0] route_ff [7];
	logic [7:0] func_ff [7];
	logic [15:0] step_ana_ff [14];
	logic [15:0] st_cnt_ff [14];
	logic [13:0] st_pa_ff;
	logic [13:0] st_px_ff;
	logic [13:0] st_l_ff;
	logic [15:0] st_hold_ff [14];
	sle_pkg::seq_state_type seq_ff;
	logic [3:0] idx_ff;
	logic tick;
	logic acc;
	logic wr_done;
	logic [31:0] nxt_prdata;
	logic nxt_err;
	logic [6:0] nxt_gen;
	logic [6:0] cfg_base;
	logic [11:0] off;
	sle_step_if sif ();

	function automatic logic pick_dig(input logic [15:0] sel, input logic [13:0] sd, input logic [7:0] di);
		logic [15:0] e;
		e = sel - `SLE_SEL_EXT_BASE;
		if (sel >= 16'h0001 && sel <= 16'h000E) begin
			return sd[sel[3:0] - 4'h1];
		end else if (sel >= `SLE_SEL_EXT_BASE && e < 16'h0008) begin
			return di[e[2:0]];
		end
		return 1'b0;
	endfunction

	function automatic logic [15:0] pick_ana(input logic [15:0] sel, input logic [15:0] sa [14],
		input logic [3:0][15:0] ai);
		logic [15:0] e;
		e = sel - `SLE_SEL_EXT_BASE;
		if (sel >= 16'h0001 && sel <= 16'h000E) begin
			return sa[sel[3:0] - 4'h1];
		end else if (sel >= `SLE_SEL_EXT_BASE && e < 16'h0004) begin
			return ai[e[1:0]];
		end
		return 16'h0000;
	endfunction

	function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
		return (a >= lo) && (a <= hi) && (a[1:0] == 2'b00);
	endfunction

	sle_tick_gen #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.tick_ff(tick)
	);

	sle_step_unit u_step (
		.s(sif)
	);

	assign acc = psel & penable & ~pready_ff;
	assign wr_done = psel & penable & pready_ff & pwrite & ~pslverr_ff;
	assign cfg_base = {3'h0, idx_ff} * 7'h05;

	always_comb begin
		sif.code = cfg_ff[cfg_base];
		sif.din_a = pick_dig(cfg_ff[cfg_base + 7'h01], step_dig_ff, dig_in);
		sif.din_b = pick_dig(cfg_ff[cfg_base + 7'h02], step_dig_ff, dig_in);
		sif.ain_a = pick_ana(cfg_ff[cfg_base + 7'h01], step_ana_ff, ana_in);
		sif.ain_b = pick_ana(cfg_ff[cfg_base + 7'h02], step_ana_ff, ana_in);
		sif.p1 = cfg_ff[cfg_base + 7'h03];
		sif.p2 = cfg_ff[cfg_base + 7'h04];
		sif.st_cnt = st_cnt_ff[idx_ff];
		sif.st_pa = st_pa_ff[idx_ff];
		sif.st_px = st_px_ff[idx_ff];
		sif.st_l = st_l_ff[idx_ff];
		sif.st_hold = st_hold_ff[idx_ff];
	end

	always_comb begin
		off = paddr - `SLE_STEP_BASE;
		nxt_prdata = 32'h0000_0000;
		nxt_err = 1'b0;
		if (paddr == `SLE_MODE_OFF) begin
			nxt_prdata = {31'h0000_0000, mode_ff};
		end else if (in_range(paddr, `SLE_STEP_BASE, `SLE_STEP_LAST)) begin
			nxt_prdata = {16'h0000, cfg_ff[off[8:2]]};
		end else if (in_range(paddr, `SLE_ROUTE_BASE, `SLE_ROUTE_LAST)) begin
			off = paddr - `SLE_ROUTE_BASE;
			nxt_prdata = {28'h000_0000, route_ff[off[4:2]]};
		end else if (in_range(paddr, `SLE_FUNC_BASE, `SLE_FUNC_LAST)) begin
			off = paddr - `SLE_FUNC_BASE;
			nxt_prdata = {24'h00_0000, func_ff[off[4:2]]};
		end else if (paddr == `SLE_STAT_DIG_OFF) begin
			nxt_prdata = {18'h0_0000, step_dig_ff};
		end else if (paddr == `SLE_STAT_OUT_OFF) begin
			nxt_prdata = {25'h000_0000, gen_out_ff};
		end else if (paddr == `SLE_RSVD_OFF) begin
			nxt_prdata = 32'h0000_0000;
		end else if (in_range(paddr, `SLE_ANA_BASE, `SLE_ANA_LAST)) begin
			off = paddr - `SLE_ANA_BASE;
			nxt_prdata = {16'h0000, step_ana_ff[off[5:2]]};
		end else begin
			nxt_err = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= acc;
			pslverr_ff <= acc & nxt_err;
			if (acc && !pwrite) begin
				prdata_ff <= nxt_prdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= `SLE_MODE_RST;
			for (int i = 0; i < 70; i++) begin
				cfg_ff[i] <= `SLE_SET_RST;
			end
			for (int i = 0; i < `SLE_NUM_OUTS; i++) begin
				route_ff[i] <= `SLE_ROUTE_RST;
				func_ff[i] <= `SLE_FUNC_RST;
			end
		end else if (wr_done) begin
			if (paddr == `SLE_MODE_OFF) begin
				mode_ff <= pwdata[0];
			end else if (in_range(paddr, `SLE_STEP_BASE, `SLE_STEP_LAST)) begin
				cfg_ff[off[8:2]] <= pwdata[15:0];
			end else if (in_range(paddr, `SLE_ROUTE_BASE, `SLE_ROUTE_LAST)) begin
				route_ff[off[4:2]] <= pwdata[3:0];
			end else if (in_range(paddr, `SLE_FUNC_BASE, `SLE_FUNC_LAST)) begin
				func_ff[off[4:2]] <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_ff <= sle_pkg::SEQ_IDLE;
			idx_ff <= 4'h0;
		end else begin
			case (seq_ff)
				sle_pkg::SEQ_IDLE: begin
					idx_ff <= 4'h0;
					if (tick && mode_ff) begin
						seq_ff <= sle_pkg::SEQ_STEP;
					end
				end
				sle_pkg::SEQ_STEP: begin
					if (!mode_ff) begin
						seq_ff <= sle_pkg::SEQ_IDLE;
					end else if (idx_ff == 4'hD) begin
						seq_ff <= sle_pkg::SEQ_PUBLISH;
					end else begin
						idx_ff <= idx_ff + 4'h1;
					end
				end
				sle_pkg::SEQ_PUBLISH: begin
					seq_ff <= sle_pkg::SEQ_IDLE;
				end
				default: begin
					seq_ff <= sle_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_dig_ff <= 14'h0000;
			st_pa_ff <= 14'h0000;
			st_px_ff <= 14'h0000;
			st_l_ff <= 14'h0000;
			for (int i = 0; i < `SLE_NUM_STEPS; i++) begin
				step_ana_ff[i] <= 16'h0000;
				st_cnt_ff[i] <= 16'h0000;
				st_hold_ff[i] <= 16'h0000;
			end
		end else if (!mode_ff) begin
			step_dig_ff <= 14'h0000;
		end else if (seq_ff == sle_pkg::SEQ_STEP) begin
			step_dig_ff[idx_ff] <= sif.dout;
			step_ana_ff[idx_ff] <= sif.aout;
			st_cnt_ff[idx_ff] <= sif.n_cnt;
			st_pa_ff[idx_ff] <= sif.n_pa;
			st_px_ff[idx_ff] <= sif.n_px;
			st_l_ff[idx_ff] <= sif.n_l;
			st_hold_ff[idx_ff] <= sif.n_hold;
		end
	end

	for (genvar g = 0; g < `SLE_NUM_OUTS; g++) begin : g_out
		always_comb begin
			if (route_ff[g] >= 4'h1 && route_ff[g] <= 4'hE) begin
				nxt_gen[g] = step_dig_ff[route_ff[g] - 4'h1] ^ func_ff[g][0];
			end else begin
				nxt_gen[g] = func_ff[g][0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_out_ff <= 7'h00;
			period_done_ff <= 1'b0;
		end else begin
			period_done_ff <= seq_ff == sle_pkg::SEQ_PUBLISH;
			if (!mode_ff) begin
				gen_out_ff <= 7'h00;
			end else if (seq_ff == sle_pkg::SEQ_PUBLISH) begin
				gen_out_ff <= nxt_gen;
			end
		end
	end
endmodule

// File: test/sle_io_model.sv
/*
 Model of the drive's digital and analog signals seen by the engine.
 Assumes the bench requests new levels; they reach the engine one pclk later.
*/
`timescale 1ns/1ps
module sle_io_model (
	// Clock.
	input wire logic pclk,
	// Levels requested by the bench.
	input wire logic [7:0] dig_req,
	input wire logic [3:0][15:0] ana_req,
	// Drive signals.
	output logic [7:0] dig_in,
	output logic [3:0][15:0] ana_in
);
	initial begin
		dig_in = 8'h00;
		ana_in = '0;
	end
	always @(posedge pclk) begin
		dig_in <= dig_req;
		ana_in <= ana_req;
	end
endmodule

// File: test/sle_engine_sva.sv
/*
 Checker of the APB answer, bypass and period timing of the engine.
 Assumes it is bound to sle_engine and sees only its ports.
*/
`timescale 1ns/1ps
module sle_engine_sva #(
	parameter int unsigned TICK_CYCLES = 20
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata_ff,
	input wire logic pready_ff,
	input wire logic pslverr_ff,
	// Engine.
	input wire logic [7:0] dig_in,
	input wire logic [3:0][15:0] ana_in,
	input wire logic [6:0] gen_out_ff,
	input wire logic [13:0] step_dig_ff,
	input wire logic period_done_ff
);
	logic mode_ff;
	logic seen_ff;
	logic [31:0] gap_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= 1'b0;
		end else if (psel && penable && pready_ff && pwrite && paddr == 12'h000) begin
			mode_ff <= pwdata[0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_ff <= 32'h0000_0000;
			seen_ff <= 1'b0;
		end else begin
			gap_ff <= period_done_ff ? 32'h0000_0001 : gap_ff + 32'h0000_0001;
			seen_ff <= mode_ff && (seen_ff || period_done_ff);
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_late: assert property (psel && penable && !pready_ff |=> pready_ff)
		else $error("pready not one cycle after access");
	chk_ready_pulse: assert property (pready_ff |=> !pready_ff)
		else $error("pready longer than one cycle");
	chk_err_with_ready: assert property (pslverr_ff |-> pready_ff)
		else $error("pslverr without pready");
	chk_rsvd_quiet: assert property (pready_ff && !pwrite && paddr == 12'h348 |-> !pslverr_ff && prdata_ff == 32'h0000_0000)
		else $error("reserved setting not quiet");
	chk_step_range: assert property (pready_ff && paddr > 12'h214 && paddr < 12'h300 |-> pslverr_ff)
		else $error("setting beyond step fourteen accepted");
	chk_bypass_clear: assert property (!mode_ff |=> gen_out_ff == 7'h00 && step_dig_ff == 14'h0000)
		else $error("outputs active in bypass");
	chk_gen_then_done: assert property ($changed(gen_out_ff) && mode_ff |-> period_done_ff)
		else $error("outputs changed outside publish");
	chk_period_gap: assert property (period_done_ff && seen_ff |-> gap_ff == TICK_CYCLES)
		else $error("period length wrong");
	chk_step_window: assert property ($changed(step_dig_ff) && mode_ff |-> ##[1:16] period_done_ff)
		else $error("step result changed outside a sweep");
	cover property (period_done_ff && gen_out_ff != 7'h00);
	cover property (pslverr_ff);
	cover property (pready_ff && paddr == 12'h348);
endmodule
bind sle_engine sle_engine_sva #(.TICK_CYCLES(TICK_CYCLES)) sle_engine_sva_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
	.pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .dig_in(dig_in), .ana_in(ana_in), .gen_out_ff(gen_out_ff),
	.step_dig_ff(step_dig_ff), .period_done_ff(period_done_ff));

// File: test/sle_engine_bench.sv
/*
 Self-checking bench of the step sequence logic engine.
 Assumes sle_engine, the io model and the checker are compiled before it.
*/
`timescale 1ns/1ps
module sle_engine_bench;
	localparam int unsigned TICK = 20;
	logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, period_done_ff, rd_e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_ff, rd_v;
	logic [7:0] dig_in, dig_req;
	logic [3:0][15:0] ana_in, ana_req;
	logic [6:0] gen_out_ff;
	logic [13:0] step_dig_ff;
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;
	sle_engine #(.TICK_CYCLES(TICK)) sle_engine_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
		.pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .dig_in(dig_in), .ana_in(ana_in),
		.gen_out_ff(gen_out_ff), .step_dig_ff(step_dig_ff), .period_done_ff(period_done_ff));
	sle_io_model sle_io_model_inst (.pclk(pclk), .dig_req(dig_req), .ana_req(ana_req), .dig_in(dig_in),
		.ana_in(ana_in));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			final_report();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready_ff !== 1'b1);
		rd_v = prdata_ff;
		rd_e = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	function automatic logic [11:0] sa(input int n, input int j);
		return 12'h100 + 12'(4 * (5 * (n - 1) + j));
	endfunction
	task automatic step(input int n, input logic [15:0] code, input logic [15:0] s1, input logic [15:0] s2,
		input logic [15:0] p1);
		wr(sa(n, 0), {16'h0000, code});
		wr(sa(n, 1), {16'h0000, s1});
		wr(sa(n, 2), {16'h0000, s2});
		wr(sa(n, 3), {16'h0000, p1});
	endtask
	task automatic per(input int k);
		repeat (k) begin
			do @(posedge pclk); while (period_done_ff !== 1'b1);
		end
	endtask
	task automatic t_regs();
		rd(12'h000);
		check(rd_v, 32'h0000_0000);
		wr(12'h348, 32'h0000_FFFF);
		rd(12'h348);
		check(rd_v, 32'h0000_0000);
		check(32'(rd_e), 32'h0000_0000);
		wr(sa(14, 4), 32'h0000_1234);
		rd(sa(14, 4));
		check(rd_v, 32'h0000_1234);
		rd(12'h218);
		check(32'(rd_e), 32'h0000_0001);
		$display("test regs done");
	endtask
	task automatic t_route();
		dig_req <= 8'h01;
		step(1, 16'h000A, 16'h0064, 16'h0000, 16'h0000);
		step(2, 16'h000A, 16'h0001, 16'h0000, 16'h0000);
		wr(12'h300, 32'h0000_0001);
		wr(12'h304, 32'h0000_0002);
		repeat (3 * TICK) @(posedge pclk);
		check(32'(gen_out_ff), 32'h0000_0000);
		check(32'(step_dig_ff), 32'h0000_0000);
		wr(12'h000, 32'h0000_0001);
		per(2);
		check(32'(step_dig_ff[1:0]), 32'h0000_0003);
		check(32'(gen_out_ff[1:0]), 32'h0000_0003);
		wr(12'h324, 32'h0000_0001);
		dig_req <= 8'h00;
		per(1);
		check(32'(^step_dig_ff[1:0]), 32'h0000_0000);
		per(1);
		check(32'(gen_out_ff[1:0]), 32'h0000_0002);
		$display("test route done");
	endtask
	task automatic t_timer();
		int ones;
		step(3, 16'h0000, 16'h0064, 16'h0000, 16'h0000);
		step(4, 16'h000B, 16'h0064, 16'h0000, 16'h0003);
		step(5, 16'h0046, 16'h0064, 16'h0000, 16'h0000);
		step(6, 16'h0014, 16'h0064, 16'h0065, 16'h0000);
		per(2);
		dig_req <= 8'h01;
		ones = 0;
		for (int i = 0; i < 6; i++) begin
			per(1);
			ones += int'(step_dig_ff[4] === 1'b1);
			check(32'(step_dig_ff[2]), 32'h0000_0000);
			if (i == 1) begin
				check(32'(step_dig_ff[3]), 32'h0000_0000);
			end
		end
		check(32'(step_dig_ff[3]), 32'h0000_0001);
		check(32'(ones), 32'h0000_0001);
		check(32'(step_dig_ff[5]), 32'h0000_0000);
		dig_req <= 8'h03;
		per(2);
		check(32'(step_dig_ff[5]), 32'h0000_0001);
		dig_req <= 8'h00;
		per(2);
		check(32'(step_dig_ff[3]), 32'h0000_0000);
		$display("test timer done");
	endtask
	task automatic t_analog();
		ana_req <= {16'h0000, 16'h0000, 16'h0030, 16'h0010};
		step(7, 16'h07D1, 16'h0064, 16'h0065, 16'h0000);
		step(8, 16'h07D7, 16'h0064, 16'h0065, 16'h0000);
		step(9, 16'h0FA1, 16'h0064, 16'h0064, 16'h0055);
		step(10, 16'h07D0, 16'h0064, 16'h0065, 16'h0000);
		per(2);
		rd(12'h398);
		check(rd_v, 32'h0000_0040);
		check(32'(step_dig_ff[7]), 32'h0000_0001);
		rd(12'h3A0);
		check(rd_v, 32'h0000_0055);
		rd(12'h3A4);
		check(rd_v, 32'h0000_0000);
		check(32'(step_dig_ff[9]), 32'h0000_0000);
		dig_req <= 8'h01;
		per(2);
		rd(12'h3A0);
		check(rd_v, 32'h0000_0010);
		$display("test analog done");
	endtask
	task automatic t_stages();
		dig_req <= 8'h00;
		step(11, 16'h006E, 16'h0064, 16'h0065, 16'h0002);
		step(12, 16'h000C, 16'h0064, 16'h0000, 16'h0002);
		step(13, 16'h07D3, 16'h0064, 16'h0065, 16'h0000);
		per(1);
		rd(12'h3B0);
		check(rd_v, 32'h0000_0030);
		dig_req <= 8'h01;
		per(1);
		check(32'(step_dig_ff[11]), 32'h0000_0001);
		dig_req <= 8'h00;
		per(1);
		check(32'(step_dig_ff[11]), 32'h0000_0001);
		per(1);
		check(32'(step_dig_ff[11]), 32'h0000_0000);
		check(32'(step_dig_ff[10]), 32'h0000_0000);
		dig_req <= 8'h01;
		per(1);
		check(32'(step_dig_ff[10]), 32'h0000_0001);
		dig_req <= 8'h02;
		per(1);
		check(32'(step_dig_ff[10]), 32'h0000_0000);
		check(32'(gen_out_ff), 32'h0000_0002);
		wr(12'h000, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		check(32'(gen_out_ff), 32'h0000_0000);
		check(32'(step_dig_ff), 32'h0000_0000);
		$display("test stages done");
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		dig_req = 8'h00;
		ana_req = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_route();
		t_timer();
		t_analog();
		t_stages();
		final_report();
	end
endmodule
